// File: inc/sacc_pkg.sv
`default_nettype none

package sacc_pkg;

    // System clock and the L/R to SCLK skew the far side may show.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned LR_SCLK_SKEW_NS = 40;
    localparam int unsigned GUARD_W = 4;
    // Longest time, so it rounds down.
    localparam logic [GUARD_W-1:0] GUARD_LOAD =
        GUARD_W'(LR_SCLK_SKEW_NS / CLK_PERIOD_NS);
    localparam logic [GUARD_W-1:0] GUARD_ZERO = 4'h0;

    // Sample word layout: 18 significant bits then 14 trailing zeros.
    localparam int unsigned WORD_BITS = 18;
    localparam int unsigned TRAIL_ZEROS = 14;
    localparam int unsigned SHIFT_W = WORD_BITS - 1 + TRAIL_ZEROS;
    localparam int unsigned PAIR_W = 2 * WORD_BITS;
    localparam int unsigned WIDE_W = WORD_BITS + 2;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 18'h00000;
    localparam logic [TRAIL_ZEROS-1:0] TRAIL_FILL = 14'h0000;
    localparam logic [SHIFT_W-1:0] SHIFT_ZERO = 31'h00000000;
    localparam logic [PAIR_W-1:0] PAIR_ZERO = 36'h000000000;

    // Decimation: 64 modulator samples of +/-1 per output word.
    localparam int unsigned DECIM_RATIO = 64;
    localparam int unsigned ACC_W = 8;
    localparam int unsigned SCALE_SH = 11;
    localparam logic signed [ACC_W-1:0] ACC_ZERO = 8'sh00;
    localparam logic signed [ACC_W-1:0] ACC_UP = 8'sh01;
    localparam logic signed [ACC_W-1:0] ACC_DOWN = 8'shFF;
    localparam logic signed [WIDE_W-1:0] WORD_MAX = 20'sh1FFFF;
    localparam logic signed [WIDE_W-1:0] WORD_MIN = 20'shE0000;

    // Output buffer.
    localparam int unsigned FIFO_DEPTH = 16;

    // Calibration length in L/R periods.
    localparam int unsigned CAL_FRAMES_DEF = 4096;
    localparam int unsigned CAL_CNT_W = 13;
    localparam logic [CAL_CNT_W-1:0] CAL_CNT_ZERO = 13'h0000;
    localparam logic [CAL_CNT_W-1:0] CAL_CNT_LAST = 13'h0001;
    localparam logic CAL_ADDR_L = 1'h0;
    localparam logic CAL_ADDR_R = 1'h1;

    // Positions of the pin inputs in the synchroniser vector.
    localparam int unsigned SY_MCLK = 0;
    localparam int unsigned SY_SCLK = 1;
    localparam int unsigned SY_LR = 2;
    localparam int unsigned SY_APWR = 3;
    localparam int unsigned SY_DPWR = 4;
    localparam int unsigned SY_CSRC = 5;
    localparam int unsigned SY_AL = 6;
    localparam int unsigned SY_AR = 7;
    localparam int unsigned SY_ZL = 8;
    localparam int unsigned SY_ZR = 9;
    localparam int unsigned SYNC_W = 10;
    localparam logic [SYNC_W-1:0] SYNC_RST = 10'h000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_L,
        ST_RD_R,
        ST_SUB_R,
        ST_PUSH
    } sacc_frame_e;

endpackage : sacc_pkg

`default_nettype wire

// File: core/sacc_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_fifo #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_flush,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] wr_next;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic push;
    logic pop;

    assign o_ready = (cnt_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_valid = (cnt_reg != '0) ? 1'b1 : 1'b0;
    assign o_data = mem_reg[rd_reg];
    assign push = i_valid & o_ready;
    assign pop = i_ready & o_valid;

    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (i_flush) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end else begin
            if (push) begin
                wr_next = wr_reg + AW'(1);
            end
            if (pop) begin
                rd_next = rd_reg + AW'(1);
            end
            cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
        if (push && !i_flush) begin
            mem_reg[wr_reg] <= i_data;
        end
    end

endmodule : sacc_fifo

`default_nettype wire

// File: core/sacc_cal_mem.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_cal_mem (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_we,
    input wire logic i_addr,
    input wire logic [sacc_pkg::WORD_BITS-1:0] i_wdata,
    output logic [sacc_pkg::WORD_BITS-1:0] o_rdata
);
    import sacc_pkg::*;

    logic [WORD_BITS-1:0] store_reg [2];
    logic [WORD_BITS-1:0] rdata_reg;

    assign o_rdata = rdata_reg;

    // Read returns the old value when read and write meet.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_reg <= WORD_ZERO;
        end else begin
            rdata_reg <= store_reg[i_addr];
        end
        if (i_we) begin
            store_reg[i_addr] <= i_wdata;
        end
    end

endmodule : sacc_cal_mem

`default_nettype wire

// File: core/sacc_top.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_top #(
    parameter int unsigned CAL_FRAMES = sacc_pkg::CAL_FRAMES_DEF
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_MASTER_CLOCK_INPUT,
    input wire logic I_BIT_CLOCK,
    input wire logic I_CHANNEL_SELECT,
    input wire logic I_ANALOG_POWERDOWN_IN,
    input wire logic I_DIGITAL_POWERDOWN_IN,
    input wire logic I_CAL_SOURCE_SELECT,
    input wire logic I_LEFT_ANALOG_IN,
    input wire logic I_RIGHT_ANALOG_IN,
    input wire logic I_LEFT_ZERO_REF_IN,
    input wire logic I_RIGHT_ZERO_REF_IN,
    output logic O_SERIAL_SAMPLE_OUT,
    output logic O_MODULATOR_CLOCK_OUT,
    output logic O_CAL_ACTIVE_OUT
);
    import sacc_pkg::*;

    function automatic logic [WORD_BITS-1:0] sat_word(
        input logic signed [WIDE_W-1:0] v
    );
        if (v > WORD_MAX) begin
            return WORD_MAX[WORD_BITS-1:0];
        end else if (v < WORD_MIN) begin
            return WORD_MIN[WORD_BITS-1:0];
        end
        return v[WORD_BITS-1:0];
    endfunction : sat_word

    function automatic logic signed [WIDE_W-1:0] widen(
        input logic [WORD_BITS-1:0] w
    );
        return {{2{w[WORD_BITS-1]}}, w};
    endfunction : widen

    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [SYNC_W-1:0] prev_reg;

    logic mclk_rise;
    logic sclk_rise;
    logic lr_rise;
    logic lr_fall;
    logic ana_off;
    logic dig_off;
    logic dig_wake;
    logic mod_sample;
    logic cal_src;
    logic bit_l;
    logic bit_r;

    logic mod_clk_reg, mod_clk_next;
    logic signed [ACC_W-1:0] acc_l_reg, acc_l_next;
    logic signed [ACC_W-1:0] acc_r_reg, acc_r_next;
    logic signed [ACC_W-1:0] step_l;
    logic signed [ACC_W-1:0] step_r;
    logic [WORD_BITS-1:0] raw_l_reg, raw_l_next;
    logic [WORD_BITS-1:0] raw_r_reg, raw_r_next;
    logic [WORD_BITS-1:0] res_l_reg, res_l_next;
    logic [WORD_BITS-1:0] res_r_reg, res_r_next;
    logic frame_zero_reg, frame_zero_next;
    logic cal_store_reg, cal_store_next;
    sacc_frame_e state_reg, state_next;
    logic cal_active_reg, cal_active_next;
    logic [CAL_CNT_W-1:0] cal_cnt_reg, cal_cnt_next;

    logic ser_out_reg, ser_out_next;
    logic [SHIFT_W-1:0] shift_reg, shift_next;
    logic [GUARD_W-1:0] guard_reg, guard_next;
    logic [WORD_BITS-1:0] right_hold_reg, right_hold_next;
    logic [WORD_BITS-1:0] load_word;

    logic mem_we;
    logic mem_addr;
    logic [WORD_BITS-1:0] mem_wdata;
    logic [WORD_BITS-1:0] mem_rdata;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [PAIR_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [PAIR_W-1:0] fifo_out_data;

    assign async_in[SY_MCLK] = I_MASTER_CLOCK_INPUT;
    assign async_in[SY_SCLK] = I_BIT_CLOCK;
    assign async_in[SY_LR] = I_CHANNEL_SELECT;
    assign async_in[SY_APWR] = I_ANALOG_POWERDOWN_IN;
    assign async_in[SY_DPWR] = I_DIGITAL_POWERDOWN_IN;
    assign async_in[SY_CSRC] = I_CAL_SOURCE_SELECT;
    assign async_in[SY_AL] = I_LEFT_ANALOG_IN;
    assign async_in[SY_AR] = I_RIGHT_ANALOG_IN;
    assign async_in[SY_ZL] = I_LEFT_ZERO_REF_IN;
    assign async_in[SY_ZR] = I_RIGHT_ZERO_REF_IN;

    // All pins are asynchronous to I_CLK; edges are taken only from the second
    // and third stages so the first stage stays a pure synchroniser.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            meta_reg <= SYNC_RST;
            sync_reg <= SYNC_RST;
            prev_reg <= SYNC_RST;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign mclk_rise = sync_reg[SY_MCLK] & ~prev_reg[SY_MCLK];
    assign sclk_rise = sync_reg[SY_SCLK] & ~prev_reg[SY_SCLK];
    assign lr_rise = sync_reg[SY_LR] & ~prev_reg[SY_LR];
    assign lr_fall = ~sync_reg[SY_LR] & prev_reg[SY_LR];
    assign ana_off = sync_reg[SY_APWR];
    assign dig_off = sync_reg[SY_DPWR];
    assign dig_wake = ~sync_reg[SY_DPWR] & prev_reg[SY_DPWR];
    // A sample is taken as the modulator clock goes high.
    assign mod_sample = mclk_rise & ~ana_off & ~mod_clk_reg;
    assign cal_src = cal_active_reg & sync_reg[SY_CSRC];
    assign bit_l = cal_src ? sync_reg[SY_ZL] : sync_reg[SY_AL];
    assign bit_r = cal_src ? sync_reg[SY_ZR] : sync_reg[SY_AR];
    assign step_l = bit_l ? ACC_UP : ACC_DOWN;
    assign step_r = bit_r ? ACC_UP : ACC_DOWN;

    assign mem_we = cal_store_reg &
        ((state_reg == ST_RD_L) || (state_reg == ST_RD_R));
    assign mem_addr = (state_reg == ST_RD_R) ? CAL_ADDR_R : CAL_ADDR_L;
    assign mem_wdata = (state_reg == ST_RD_R) ? raw_r_reg : raw_l_reg;
    assign fifo_in_valid = (state_reg == ST_PUSH) ? 1'b1 : 1'b0;
    assign fifo_in_data = frame_zero_reg ? PAIR_ZERO
                                         : {res_l_reg, res_r_reg};
    assign fifo_out_ready = lr_rise & ~dig_off;
    assign load_word = lr_rise
        ? (fifo_out_valid ? fifo_out_data[PAIR_W-1:WORD_BITS] : WORD_ZERO)
        : right_hold_reg;

    always_comb begin
        mod_clk_next = mod_clk_reg;
        acc_l_next = acc_l_reg;
        acc_r_next = acc_r_reg;
        raw_l_next = raw_l_reg;
        raw_r_next = raw_r_reg;
        res_l_next = res_l_reg;
        res_r_next = res_r_reg;
        frame_zero_next = frame_zero_reg;
        cal_store_next = cal_store_reg;
        state_next = state_reg;
        cal_active_next = cal_active_reg;
        cal_cnt_next = cal_cnt_reg;

        if (ana_off) begin
            mod_clk_next = 1'b0;
        end else if (mclk_rise) begin
            mod_clk_next = ~mod_clk_reg;
        end

        if (dig_off) begin
            acc_l_next = ACC_ZERO;
            acc_r_next = ACC_ZERO;
            state_next = ST_IDLE;
            cal_active_next = 1'b0;
            cal_cnt_next = CAL_CNT_ZERO;
        end else begin
            if (lr_rise) begin
                // Both channels are dumped at the same instant.
                acc_l_next = mod_sample ? step_l : ACC_ZERO;
                acc_r_next = mod_sample ? step_r : ACC_ZERO;
            end else if (mod_sample) begin
                acc_l_next = acc_l_reg + step_l;
                acc_r_next = acc_r_reg + step_r;
            end

            if (dig_wake) begin
                cal_active_next = 1'b1;
                cal_cnt_next = CAL_CNT_W'(CAL_FRAMES);
            end else if (lr_rise && cal_active_reg) begin
                cal_cnt_next = cal_cnt_reg - CAL_CNT_LAST;
                if (cal_cnt_reg == CAL_CNT_LAST) begin
                    cal_active_next = 1'b0;
                end
            end

            // An L/R rise that comes while a frame is still in flight starts no new
            // frame, so its word is dropped; at any legal word rate the pipe is idle long before.
            case (state_reg)
                ST_IDLE: begin
                    if (lr_rise) begin
                        raw_l_next = sat_word({acc_l_reg[ACC_W-1], acc_l_reg,
                            {SCALE_SH{1'b0}}});
                        raw_r_next = sat_word({acc_r_reg[ACC_W-1], acc_r_reg,
                            {SCALE_SH{1'b0}}});
                        frame_zero_next = cal_active_reg;
                        cal_store_next = cal_active_reg &&
                            (cal_cnt_reg == CAL_CNT_LAST);
                        state_next = ST_RD_L;
                    end
                end
                ST_RD_L: begin
                    state_next = ST_RD_R;
                end
                ST_RD_R: begin
                    res_l_next = sat_word(widen(raw_l_reg) -
                        widen(mem_rdata));
                    state_next = ST_SUB_R;
                end
                ST_SUB_R: begin
                    res_r_next = sat_word(widen(raw_r_reg) -
                        widen(mem_rdata));
                    state_next = ST_PUSH;
                end
                ST_PUSH: begin
                    // Back-pressure from a full buffer holds the frame.
                    if (fifo_in_ready) begin
                        state_next = ST_IDLE;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        ser_out_next = ser_out_reg;
        shift_next = shift_reg;
        guard_next = guard_reg;
        right_hold_next = right_hold_reg;
        if (dig_off) begin
            ser_out_next = 1'b0;
            shift_next = SHIFT_ZERO;
            guard_next = GUARD_ZERO;
            right_hold_next = WORD_ZERO;
        end else if (lr_rise || lr_fall) begin
            if (lr_rise) begin
                right_hold_next = fifo_out_valid
                    ? fifo_out_data[WORD_BITS-1:0] : WORD_ZERO;
            end
            ser_out_next = load_word[WORD_BITS-1];
            shift_next = {load_word[WORD_BITS-2:0], TRAIL_FILL};
            // The SCLK rise that comes with the L/R edge is not a shift.
            guard_next = GUARD_LOAD;
        end else begin
            if (guard_reg != GUARD_ZERO) begin
                guard_next = guard_reg - GUARD_ZERO - 4'h1;
            end
            if (sclk_rise && (guard_reg == GUARD_ZERO)) begin
                ser_out_next = shift_reg[SHIFT_W-1];
                shift_next = {shift_reg[SHIFT_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            mod_clk_reg <= 1'b0;
            acc_l_reg <= ACC_ZERO;
            acc_r_reg <= ACC_ZERO;
            raw_l_reg <= WORD_ZERO;
            raw_r_reg <= WORD_ZERO;
            res_l_reg <= WORD_ZERO;
            res_r_reg <= WORD_ZERO;
            frame_zero_reg <= 1'b0;
            cal_store_reg <= 1'b0;
            state_reg <= ST_IDLE;
            cal_active_reg <= 1'b0;
            cal_cnt_reg <= CAL_CNT_ZERO;
            ser_out_reg <= 1'b0;
            shift_reg <= SHIFT_ZERO;
            guard_reg <= GUARD_ZERO;
            right_hold_reg <= WORD_ZERO;
        end else begin
            mod_clk_reg <= mod_clk_next;
            acc_l_reg <= acc_l_next;
            acc_r_reg <= acc_r_next;
            raw_l_reg <= raw_l_next;
            raw_r_reg <= raw_r_next;
            res_l_reg <= res_l_next;
            res_r_reg <= res_r_next;
            frame_zero_reg <= frame_zero_next;
            cal_store_reg <= cal_store_next;
            state_reg <= state_next;
            cal_active_reg <= cal_active_next;
            cal_cnt_reg <= cal_cnt_next;
            ser_out_reg <= ser_out_next;
            shift_reg <= shift_next;
            guard_reg <= guard_next;
            right_hold_reg <= right_hold_next;
        end
    end

    assign O_SERIAL_SAMPLE_OUT = ser_out_reg;
    assign O_MODULATOR_CLOCK_OUT = mod_clk_reg;
    assign O_CAL_ACTIVE_OUT = cal_active_reg;

    sacc_cal_mem u_cal_mem (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    sacc_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_flush(dig_off),
        .i_valid(fifo_in_valid),
        .o_ready(fifo_in_ready),
        .i_data(fifo_in_data),
        .o_valid(fifo_out_valid),
        .i_ready(fifo_out_ready),
        .o_data(fifo_out_data)
    );

endmodule : sacc_top

`default_nettype wire

// File: test/sacc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_monitor #(
    parameter int unsigned CAL_FRAMES = 4096
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_MASTER_CLOCK_INPUT,
    input wire logic I_BIT_CLOCK,
    input wire logic I_CHANNEL_SELECT,
    input wire logic I_ANALOG_POWERDOWN_IN,
    input wire logic I_DIGITAL_POWERDOWN_IN,
    input wire logic O_SERIAL_SAMPLE_OUT,
    input wire logic O_MODULATOR_CLOCK_OUT,
    input wire logic O_CAL_ACTIVE_OUT
);
    // Edges are taken from the raw pins, so every window below allows for
    // the designer's three-cycle synchroniser lag.
    logic lr_reg, lr_next, sck_reg, sck_next, lr_edge, sck_rise;
    logic [15:0] rise_reg, rise_next;
    logic [5:0] bit_reg, bit_next;
    logic [3:0] since_reg, since_next;

    always_comb begin
        lr_edge = I_CHANNEL_SELECT != lr_reg;
        sck_rise = I_BIT_CLOCK && !sck_reg;
        lr_next = I_CHANNEL_SELECT;
        sck_next = I_BIT_CLOCK;
        rise_next = O_CAL_ACTIVE_OUT ?
            rise_reg + 16'(lr_edge && I_CHANNEL_SELECT) : 16'h0000;
        bit_next = lr_edge ? 6'h00 : bit_reg + 6'(sck_rise && bit_reg != 6'h3F);
        since_next = (lr_edge || sck_rise) ? 4'h0 :
            since_reg + 4'(since_reg != 4'hF);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            {lr_reg, sck_reg, rise_reg, bit_reg, since_reg} <= '0;
        end else begin
            {lr_reg, sck_reg} <= {lr_next, sck_next};
            {rise_reg, bit_reg, since_reg} <= {rise_next, bit_next, since_next};
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_cal_up;
        ##[2:5] O_CAL_ACTIVE_OUT;
    endsequence
    property p_ana_hold;
        I_ANALOG_POWERDOWN_IN [*5] |-> !O_MODULATOR_CLOCK_OUT;
    endproperty
    property p_modclk_edge;
        $changed(O_MODULATOR_CLOCK_OUT) |-> ($past(I_MASTER_CLOCK_INPUT, 2)
            && !$past(I_MASTER_CLOCK_INPUT, 6)) || $past(I_ANALOG_POWERDOWN_IN, 3);
    endproperty
    property p_cal_start;
        $fell(I_DIGITAL_POWERDOWN_IN) |-> s_cal_up;
    endproperty
    property p_cal_cause;
        $rose(O_CAL_ACTIVE_OUT) |-> $past(I_DIGITAL_POWERDOWN_IN, 6)
            && !$past(I_DIGITAL_POWERDOWN_IN, 2);
    endproperty
    property p_cal_len;
        $fell(O_CAL_ACTIVE_OUT) |-> rise_reg == CAL_FRAMES;
    endproperty
    property p_cal_bound;
        O_CAL_ACTIVE_OUT |-> rise_reg <= CAL_FRAMES;
    endproperty
    property p_cal_zero;
        O_CAL_ACTIVE_OUT && rise_reg >= 2 |-> !O_SERIAL_SAMPLE_OUT;
    endproperty
    property p_trail_zero;
        bit_reg >= 19 && bit_reg <= 31 |-> !O_SERIAL_SAMPLE_OUT;
    endproperty
    property p_launch;
        $changed(O_SERIAL_SAMPLE_OUT) |-> (since_reg >= 1 && since_reg <= 6)
            || $past(I_DIGITAL_POWERDOWN_IN, 3);
    endproperty
    property p_dig_hold;
        I_DIGITAL_POWERDOWN_IN [*8] |-> !O_CAL_ACTIVE_OUT && !O_SERIAL_SAMPLE_OUT;
    endproperty

    a_ana_hold: assert property (p_ana_hold)
        else $error("modulator clock runs in analog power-down");
    a_modclk_edge: assert property (p_modclk_edge)
        else $error("modulator clock moved without a master rise");
    a_cal_start: assert property (p_cal_start)
        else $error("calibration did not start");
    a_cal_cause: assert property (p_cal_cause)
        else $error("calibration started without power-down release");
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
    a_cal_bound: assert property (p_cal_bound)
        else $error("calibration overran");
    a_cal_zero: assert property (p_cal_zero)
        else $error("nonzero data during calibration");
    a_trail_zero: assert property (p_trail_zero)
        else $error("trailing bit not zero");
    a_launch: assert property (p_launch)
        else $error("data changed away from a clock edge");
    a_dig_hold: assert property (p_dig_hold)
        else $error("digital section active in power-down");
endmodule : sacc_monitor

bind sacc_top sacc_monitor #(.CAL_FRAMES(CAL_FRAMES)) i_mon (
    .I_CLK, .I_RESET, .I_MASTER_CLOCK_INPUT, .I_BIT_CLOCK, .I_CHANNEL_SELECT,
    .I_ANALOG_POWERDOWN_IN, .I_DIGITAL_POWERDOWN_IN, .O_SERIAL_SAMPLE_OUT,
    .O_MODULATOR_CLOCK_OUT, .O_CAL_ACTIVE_OUT
);

`default_nettype wire

// File: test/sacc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module sacc_rx_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_sdo,
    output logic o_mclk,
    output logic o_sclk,
    output logic o_lr,
    output logic [31:0] o_left,
    output logic [31:0] o_right,
    output logic [15:0] o_frames
);
    // One 1024-cycle frame counter makes all framing clocks, so they can
    // never drift against each other.
    logic [9:0] cnt = 10'h000;
    logic [31:0] sh = 32'h0;

    always @(posedge i_clk) begin
        cnt <= #1 i_reset ? 10'h000 : cnt + 10'h001;
    end

    // The master clock is scaled to the sim clock; only its ratio to the
    // word rate matters to the logic.
    assign o_mclk = cnt[2];
    assign o_sclk = ~cnt[3];
    assign o_lr = ~cnt[9];

    // Each bit is taken late in its slot, well after the launch delay.
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_frames <= 16'h0000;
        end else if (cnt[3:0] == 4'hC) begin
            sh <= {sh[30:0], i_sdo};
            if (cnt[8:4] == 5'h1F && !cnt[9]) begin
                o_left <= {sh[30:0], i_sdo};
            end else if (cnt[8:4] == 5'h1F) begin
                o_right <= {sh[30:0], i_sdo};
                o_frames <= o_frames + 16'h0001;
            end
        end
    end
endmodule : sacc_rx_model

`default_nettype wire

// File: test/tb_stereo_adc_serial_cal_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_stereo_adc_serial_cal_ctrl;
    import sacc_pkg::*;
    localparam int unsigned CAL_N = 4;
    localparam int unsigned FRAME = 1024;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ana_pd = 1'b0;
    logic dig_pd = 1'b0;
    logic src = 1'b0;
    logic al = 1'b0, ar = 1'b0, zl = 1'b0, zr = 1'b0;
    logic mclk, sclk, lr, sdo, modclk, cal;
    logic [31:0] wl, wr;
    logic [15:0] frames;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    sacc_top #(.CAL_FRAMES(CAL_N)) i_dut (
        .I_CLK(clk), .I_RESET(rst), .I_MASTER_CLOCK_INPUT(mclk),
        .I_BIT_CLOCK(sclk), .I_CHANNEL_SELECT(lr),
        .I_ANALOG_POWERDOWN_IN(ana_pd), .I_DIGITAL_POWERDOWN_IN(dig_pd),
        .I_CAL_SOURCE_SELECT(src), .I_LEFT_ANALOG_IN(al),
        .I_RIGHT_ANALOG_IN(ar), .I_LEFT_ZERO_REF_IN(zl),
        .I_RIGHT_ZERO_REF_IN(zr), .O_SERIAL_SAMPLE_OUT(sdo),
        .O_MODULATOR_CLOCK_OUT(modclk), .O_CAL_ACTIVE_OUT(cal)
    );
    sacc_rx_model i_far (
        .i_clk(clk), .i_reset(rst), .i_sdo(sdo), .o_mclk(mclk),
        .o_sclk(sclk), .o_lr(lr), .o_left(wl), .o_right(wr),
        .o_frames(frames)
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
            err_count++;
        end
    endtask : chk

    task automatic frames_wait(input int n);
        repeat (n) @(frames);
        tick(1);
    endtask : frames_wait

    // Streams are held constant so each decimated word saturates exactly,
    // whatever the sample phase within the frame.
    task automatic t_cal(input logic s, input logic [3:0] pins,
        input logic [1:0] after, input logic [17:0] el, input logic [17:0] er);
        time t0;
        {zl, zr, al, ar} = pins;
        src = s;
        frames_wait(1);
        tick(200);
        dig_pd = 1'b1;
        tick(20);
        dig_pd = 1'b0;
        tick(6);
        chk(32'h1, cal);
        t0 = $time;
        frames_wait(3);
        chk(32'h0, wl);
        chk(32'h0, wr);
        while (cal === 1'b1) tick(1);
        chk(32'h1, ($time - t0) / CLK_PERIOD_NS > (CAL_N - 1) * FRAME
            && ($time - t0) / CLK_PERIOD_NS < CAL_N * FRAME);
        {al, ar} = after;
        frames_wait(4);
        chk({el, TRAIL_FILL}, wl);
        chk({er, TRAIL_FILL}, wr);
        $display("calibration test with source %0d done", s);
    endtask : t_cal

    task automatic t_ana_pd;
        int hi = 0;
        int rises = 0;
        logic p;
        ana_pd = 1'b1;
        tick(10);
        repeat (100) begin
            if (modclk !== 1'b0) hi++;
            tick(1);
        end
        chk(32'h0, hi);
        @(negedge mclk);
        ana_pd = 1'b0;
        tick(20);
        p = modclk;
        repeat (64) begin
            tick(1);
            if (modclk === 1'b1 && p === 1'b0) rises++;
            p = modclk;
        end
        chk(32'h4, rises);
        $display("analog power-down test done");
    endtask : t_ana_pd

    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        tick(5);
        rst = 1'b0;
        tick(10);
        t_cal(1'b1, 4'b1001, 2'b11, 18'h00000, 18'h1FFFF);
        t_cal(1'b0, 4'b0110, 2'b00, 18'h20000, 18'h00000);
        t_ana_pd();
        summarize();
    end
endmodule : tb_stereo_adc_serial_cal_ctrl

`default_nettype wire
